// ===== hdl/fault_log_and_mask_registers.sv
// fault log and error mask register bank of the supply supervisor
//
// Behaviour
// - summary bit 7 of supply log set when any monitored change logged since read
// - supply log bits 6..0: positive four..one, high voltage, bipolar two, one
// - input log bits 3..0 set when logic inputs four..one changed since read
// - input log bit 4 set when watchdog output changed since last read
// - both fault logs read-only, zero after reset
// - supply mask bits 6..0 stop matching supply faults being logged
// - input mask bit 4 stops watchdog changes being logged
// - input mask bits 3..0 stop logic input changes being logged
// - both masks read/write, zero after reset, nothing masked
// - reading the input fault log clears the latched fault contents
// - summary bit has no mask bit; masks never hide it directly
// - log changes either direction; freeze contents once summary bit set
`timescale 1ns/1ps
module fault_log_and_mask_registers
    import fault_log_pkg::*;
(
    input  wire logic                           ref_clk,
    input  wire logic                           reset,
    input  wire fault_log_pkg::fault_sources_s  sources,
    input  wire fault_log_pkg::reg_request_s    request,
    output logic      [7:0]                     reg_rdata,
    output logic                                any_fault_summary
);
    import fault_log_pkg::*;

    typedef struct packed {
        logic [7:0] supply_error_mask;
        logic [7:0] input_error_mask;
        logic [7:0] supply_fault_log;
        logic [7:0] input_fault_log;
        logic [7:0] rdata;
    } bank_state_s;

    bank_state_s             state;
    bank_state_s             next_state;
    logic [SOURCE_COUNT-1:0] level;
    logic [SOURCE_COUNT-1:0] change;
    logic [SOURCE_COUNT-1:0] unmasked;
    logic [SOURCE_COUNT-1:0] event_vec;
    logic                    any_event;
    logic                    log_read;

    // ------------------------------------------------------------
    // source synchronising and change detection
    // ------------------------------------------------------------
    source_change_detect u_detect (
        .ref_clk (ref_clk),
        .reset   (reset),
        .raw     (sources),
        .level   (level),
        .change  (change)
    );

    // ------------------------------------------------------------
    // masking
    // ------------------------------------------------------------
    assign unmasked  = ~{state.input_error_mask[WATCHDOG_BIT:0],
                         state.supply_error_mask[SUPPLY_COUNT-1:0]};
    assign event_vec = change & unmasked;
    assign any_event = |event_vec;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    assign log_read = request.rd && addr_is(request.addr, INPUT_FAULT_LOG_ADDR);

    // ------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // mask writes; log registers take no writes
        if (request.wr && addr_is(request.addr, SUPPLY_ERROR_MASK_ADDR)) begin
            next_state.supply_error_mask = request.wdata & SUPPLY_MASK_BITS;
        end else if (request.wr && addr_is(request.addr, INPUT_ERROR_MASK_ADDR)) begin
            next_state.input_error_mask = request.wdata & INPUT_MASK_BITS;
        end

        // read data is sampled before the clear takes effect
        if (!request.rd) begin
            next_state.rdata = state.rdata;
        end else if (addr_is(request.addr, SUPPLY_ERROR_MASK_ADDR)) begin
            next_state.rdata = state.supply_error_mask;
        end else if (addr_is(request.addr, INPUT_ERROR_MASK_ADDR)) begin
            next_state.rdata = state.input_error_mask;
        end else if (addr_is(request.addr, SUPPLY_FAULT_LOG_ADDR)) begin
            next_state.rdata = state.supply_fault_log;
        end else if (addr_is(request.addr, INPUT_FAULT_LOG_ADDR)) begin
            next_state.rdata = state.input_fault_log;
        end else begin
            next_state.rdata = REG_RESET;
        end

        // an event in the clearing cycle is logged afresh, so it is not lost
        if (log_read) begin
            next_state.supply_fault_log = REG_RESET;
            next_state.input_fault_log  = REG_RESET;
        end
        if ((log_read || !state.supply_fault_log[SUMMARY_BIT]) && any_event) begin
            next_state.supply_fault_log[SUMMARY_BIT] = 1'b1;
            // supply bits hold the detector level seen at the logged change
            next_state.supply_fault_log[SUPPLY_COUNT-1:0] =
                level[SUPPLY_COUNT-1:0] & unmasked[SUPPLY_COUNT-1:0];
            next_state.input_fault_log[WATCHDOG_BIT:0] =
                event_vec[SOURCE_COUNT-1:SUPPLY_COUNT];
        end
    end

    assign reg_rdata         = state.rdata;
    assign any_fault_summary = state.supply_fault_log[SUMMARY_BIT];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ===== hdl/fault_log_pkg.sv
// constants and carrier types for the fault log and mask register bank
package fault_log_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SUPPLY_ERROR_MASK_ADDR = 8'h9D;
    localparam logic [7:0] INPUT_ERROR_MASK_ADDR  = 8'h9E;
    localparam logic [7:0] SUPPLY_FAULT_LOG_ADDR  = 8'hDC;
    localparam logic [7:0] INPUT_FAULT_LOG_ADDR   = 8'hDD;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         SUPPLY_COUNT     = 7;
    localparam int         LOGIC_COUNT      = 4;
    localparam int         SOURCE_COUNT     = 12;
    localparam int         SUMMARY_BIT      = 7;
    localparam int         WATCHDOG_BIT     = 4;
    localparam logic [7:0] SUPPLY_MASK_BITS = 8'h7F;
    localparam logic [7:0] INPUT_MASK_BITS  = 8'h1F;
    localparam logic [7:0] REG_RESET        = 8'h00;

    // supply bits 6..0: positive 4,3,2,1, high voltage, bipolar 2,1
    typedef struct packed {
        logic       watchdog_detector_output;
        logic [3:0] general_logic_input;
        logic [6:0] supply_fault_detector;
    } fault_sources_s;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_request_s;

endpackage

// ===== hdl/source_change_detect.sv
// synchroniser and change detector for the monitored sources
`timescale 1ns/1ps
module source_change_detect
    import fault_log_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic [SOURCE_COUNT-1:0] raw,
    output logic      [SOURCE_COUNT-1:0] level,
    output logic      [SOURCE_COUNT-1:0] change
);
    typedef struct packed {
        logic [SOURCE_COUNT-1:0] sync1;
        logic [SOURCE_COUNT-1:0] sync2;
        logic [SOURCE_COUNT-1:0] prev;
        logic [1:0]              primed;
    } detect_state_s;

    detect_state_s state;
    detect_state_s next_state;

    // ------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_state.sync1  = raw;
        next_state.sync2  = state.sync1;
        next_state.prev   = state.sync2;
        next_state.primed = (state.primed == 2'h3) ? 2'h3 : state.primed + 2'h1;
    end

    // priming waits until prev holds a real sample, so the level at release is the baseline
    assign level  = state.sync2;
    assign change = (state.primed == 2'h3) ? (state.sync2 ^ state.prev) : '0;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ===== verif/fault_log_monitor.sv
// checker for the fault log and mask register bank
`timescale 1ns/1ps
module fault_log_monitor
    import fault_log_pkg::*;
(
    input wire logic                          ref_clk,
    input wire logic                          reset,
    input wire fault_log_pkg::fault_sources_s sources,
    input wire fault_log_pkg::reg_request_s   request,
    input wire logic [7:0]                    reg_rdata,
    input wire logic                          any_fault_summary
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // cycles since the pins last moved; the two flop synchroniser makes logging lag
    fault_sources_s prv;
    logic [2:0]     q;
    wire            rd_dd = request.rd && request.addr == INPUT_FAULT_LOG_ADDR;
    wire            rd_dc = request.rd && request.addr == SUPPLY_FAULT_LOG_ADDR;
    always_ff @(posedge ref_clk) begin
        prv <= sources;
        q   <= (reset || sources != prv) ? 3'h0 : (q == 3'h7 ? q : q + 3'h1);
    end
    property p_rst; disable iff (1'b0) reset |=> reg_rdata == 8'h00 && !any_fault_summary; endproperty
    a_rst: assert property (p_rst) else $error("outputs not zero after reset");
    property p_clear; rd_dd && q >= 3'h5 |=> !any_fault_summary; endproperty
    a_clear: assert property (p_clear) else $error("summary not cleared by read");
    property p_hold; any_fault_summary && !rd_dd |=> any_fault_summary; endproperty
    a_hold: assert property (p_hold) else $error("summary dropped without read");
    property p_rise; $rose(any_fault_summary) |-> q inside {[2:4]}; endproperty
    a_rise: assert property (p_rise) else $error("summary rose without change");
    property p_stand; !request.rd |=> $stable(reg_rdata); endproperty
    a_stand: assert property (p_stand) else $error("read data moved without read");
    property p_bit7; rd_dc |=> reg_rdata[7] == $past(any_fault_summary); endproperty
    a_bit7: assert property (p_bit7) else $error("log bit 7 differs from summary");
    property p_unmap; request.rd && request.addr < 8'h80 |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_wmask;
        request.wr && !request.rd && request.addr == SUPPLY_ERROR_MASK_ADDR ##1 request.rd &&
        request.addr == SUPPLY_ERROR_MASK_ADDR |=> reg_rdata == ($past(request.wdata, 2) & 8'h7F);
    endproperty
    a_wmask: assert property (p_wmask) else $error("mask readback wrong");
endmodule

bind fault_log_and_mask_registers fault_log_monitor u_mon (.ref_clk(ref_clk), .reset(reset),
    .sources(sources), .request(request), .reg_rdata(reg_rdata),
    .any_fault_summary(any_fault_summary));

// ===== verif/tb_fault_log_and_mask_registers.sv
// self-checking bench for the fault log and mask register bank
`timescale 1ns/1ps
module tb_fault_log_and_mask_registers;
    import fault_log_pkg::*;
    logic           ref_clk = 0;
    logic           reset   = 1;
    fault_sources_s sources = '0;
    reg_request_s   request = '0;
    logic [7:0]     reg_rdata;
    logic           any_fault_summary;
    int             n_fail = 0;
    int             cmp_count = 0;
    int             cyc = 0;
    fault_sources_s prv, nxt;
    logic [7:0]     m1, m2, rv;
    logic [16:0]    e;
    logic [7:0]     adr [4];
    always #50 ref_clk = ~ref_clk;
    fault_log_and_mask_registers DUT (.ref_clk(ref_clk), .reset(reset), .sources(sources),
        .request(request), .reg_rdata(reg_rdata), .any_fault_summary(any_fault_summary));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobes stay until the next call, so back to back cycles never move a signal twice
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        request = '{addr: a, wr: w, rd: r, wdata: d};
        @(posedge ref_clk);
        #1;
        rv = reg_rdata;
    endtask
    // first unmasked change decides the logs; supply bits hold levels, input bits hold changes
    function automatic logic [16:0] ev(fault_sources_s a, fault_sources_s b, logic [7:0] k1,
                                       logic [7:0] k2);
        logic [11:0] d;
        d = (a ^ b) & ~{k2[4:0], k1[6:0]};
        if (d == '0) return '0;
        return {2'b11, b.supply_fault_detector & ~k1[6:0], 3'h0, d[11:7]};
    endfunction
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        void'($urandom(21771));
        adr = '{SUPPLY_ERROR_MASK_ADDR, INPUT_ERROR_MASK_ADDR, SUPPLY_FAULT_LOG_ADDR,
                INPUT_FAULT_LOG_ADDR};
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 0;
        foreach (adr[i]) begin
            acc(0, 1, adr[i], 8'h00);
            chk(rv, REG_RESET);
        end
        prv = sources;
        for (int it = 0; it < 40; it++) begin
            m1 = it == 0 ? 8'hFF : (it == 1 ? 8'h00 : 8'($urandom));
            m2 = it == 0 ? 8'hFF : (it == 1 ? 8'h00 : 8'($urandom));
            acc(1, 0, SUPPLY_ERROR_MASK_ADDR, m1);
            acc(0, 1, SUPPLY_ERROR_MASK_ADDR, 8'h00);
            chk(rv, m1 & SUPPLY_MASK_BITS);
            acc(1, 0, INPUT_ERROR_MASK_ADDR, m2);
            acc(0, 1, INPUT_ERROR_MASK_ADDR, 8'h00);
            chk(rv, m2 & INPUT_MASK_BITS);
            acc(1, 0, SUPPLY_FAULT_LOG_ADDR, 8'hFF);
            acc(0, 1, {1'b0, 7'($urandom)}, 8'h00);
            chk(rv, 8'h00);
            nxt = it < 2 ? ~prv : 12'($urandom);
            sources = nxt;
            e = ev(prv, nxt, m1, m2);
            repeat (6) acc(0, 0, 8'h00, 8'h00);
            chk({7'h0, any_fault_summary}, {7'h0, e[16]});
            prv = nxt;
            nxt = 12'($urandom);
            sources = nxt;
            if (!e[16]) e = ev(prv, nxt, m1, m2);
            repeat (6) acc(0, 0, 8'h00, 8'h00);
            acc(0, 1, SUPPLY_FAULT_LOG_ADDR, 8'h00);
            chk(rv, e[15:8]);
            acc(0, 1, INPUT_FAULT_LOG_ADDR, 8'h00);
            chk(rv, e[7:0]);
            acc(0, 1, SUPPLY_FAULT_LOG_ADDR, 8'h00);
            chk(rv, 8'h00);
            prv = nxt;
        end
        // mid-run reset with live sources: the level at release must not log a change
        sources = 12'($urandom) | 12'h001;
        reset   = 1;
        repeat (3) acc(0, 0, 8'h00, 8'h00);
        reset = 0;
        repeat (6) acc(0, 0, 8'h00, 8'h00);
        chk({7'h0, any_fault_summary}, 8'h00);
        acc(0, 1, INPUT_FAULT_LOG_ADDR, 8'h00);
        chk(rv, REG_RESET);
        test_done();
    end
endmodule
